// ### rtl/ssrc_regs.vh
// Purpose: Register map, field positions, reset values and timing of
//          the shutdown and reset controller.
// Assumes: Register indices times four give the AXI byte address.
// Notes:   Definitions only; included by bare name.
`ifndef SSRC_REGS_VH
`define SSRC_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define SSRC_IDX_ID        10'h000
`define SSRC_IDX_REV       10'h001
`define SSRC_IDX_SOFTSD    10'h04c
`define SSRC_IDX_ERROR_ACTION_BIT    10'h04e
`define SSRC_IDX_CAUSE     10'h052
`define SSRC_IDX_IRQSTS    10'h060
`define SSRC_IDX_IRQMSK    10'h061
`define SSRC_IDX_STATE     10'h062

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSRC_SOFTSD_BIT    13
`define SSRC_REV_LSB       12
`define SSRC_CAUSE_SOFT    13
`define SSRC_CAUSE_PIN     11
`define SSRC_CAUSE_CDEL    10
`define SSRC_COND_MSB      9
`define SSRC_IRQ_SDSTART   0
`define SSRC_IRQ_SDDONE    1
`define SSRC_IRQ_UP        2

// ----------------------------------------------------------------
// Reset values and identity (identity values are arbitrary)
// ----------------------------------------------------------------
`define SSRC_SOFTSD_RST    16'h0000
`define SSRC_ERROR_ACTION_BIT_RST    16'h0200
`define SSRC_CAUSE_RST     16'h0000
`define SSRC_IRQ_RST       3'h0
`define SSRC_DEV_ID        16'h5a3c
`define SSRC_REV_ID        3'h5

// ----------------------------------------------------------------
// Bus answers and timing
// ----------------------------------------------------------------
`define SSRC_RESP_OK       2'h0
`define SSRC_RESP_ERR      2'h2
`define SSRC_CLK_NS        20
`define SSRC_STEP_NS       1000
`define SSRC_STEP_CYC      ((`SSRC_STEP_NS + `SSRC_CLK_NS - 1) / `SSRC_CLK_NS)

`endif

// ### rtl/ssrc_top.v
// Purpose: Shutdown and reset controller with AXI4-Lite registers.
// Assumes: One 50 MHz clock; condition inputs are asynchronous levels.
// Notes:   Regulator and codec enables are single summary outputs.
//
// Overview of operation
// - Enabled temperature/voltage conditions start device shutdown
// - Charge-delay error always starts device shutdown
// - Low run pin or soft bit: ordered shutdown
// - After soft shutdown, run pin needs low first
// - Soft-shutdown bit 13, resets to zero
// - Cause bits 13, 11, 10 for soft, pin, delay
// - Cause bits 9..6 temperature, battery, lockout
// - Cause bits 5..0 buck and linear regulator undervoltage
// - Registers stay accessible after any shutdown
// - Any write to index zero resets registers
// - Software reset drops regulators and system reset
// - After software reset, restart needs run-pin toggle
// - Index zero reads the device identification code
// - Index one reads revision in bits 14:12
// - Run pin low powers down; high restarts
`timescale 1ns/1ns
`include "ssrc_regs.vh"

module ssrc_top #(
   parameter [15:0] DEV_ID = `SSRC_DEV_ID,
   parameter [2:0]  REV_ID = `SSRC_REV_ID
) (
   // Clock and reset
   input  wire        clk_i,
   input  wire        resetn_i,
   // AXI4-Lite write address and data
   input  wire [11:0] s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output wire        s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output wire        s_axi_wready_o,
   // AXI4-Lite write response
   output wire [1:0]  s_axi_bresp_o,
   output wire        s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   // AXI4-Lite read
   input  wire [11:0] s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output wire        s_axi_arready_o,
   output wire [31:0] s_axi_rdata_o,
   output wire [1:0]  s_axi_rresp_o,
   output wire        s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   // Run pin and fault conditions (asynchronous)
   input  wire        run_pin_i,
   input  wire        charge_delay_err_i,
   input  wire        temp_level2_i,
   input  wire        temp_level1_i,
   input  wire        batt_cmp_uv_i,
   input  wire        uvlo_i,
   input  wire        buck2_uv_i,
   input  wire        buck1_uv_i,
   input  wire        linreg4_uv_i,
   input  wire        linreg3_uv_i,
   input  wire        linreg2_uv_i,
   input  wire        linreg1_uv_i,
   // Power, codec and reset controls
   output wire        codec_en_o,
   output wire        power_en_o,
   output wire        system_reset_n_o,
   // Interrupt
   output wire        irq_o
);

   // ----------------------------------------------------------------
   // Constants
   // ----------------------------------------------------------------
   localparam [4:0]  ST_OFF    = 5'h01;
   localparam [4:0]  ST_START  = 5'h02;
   localparam [4:0]  ST_RUN    = 5'h04;
   localparam [4:0]  ST_SDCDC  = 5'h08;
   localparam [4:0]  ST_SDPWR  = 5'h10;
   // Step count is an integer expression; cut to the counter width
   localparam [31:0] STEP_CYC  = `SSRC_STEP_CYC;
   localparam [15:0] STEP_LAST = STEP_CYC[15:0] - 16'h0001;

   // Register index is mapped
   function mapped;
      input [9:0] idx;
      begin
         mapped = (idx == `SSRC_IDX_ID)     || (idx == `SSRC_IDX_REV)    ||
                  (idx == `SSRC_IDX_SOFTSD) || (idx == `SSRC_IDX_ERROR_ACTION_BIT) ||
                  (idx == `SSRC_IDX_CAUSE)  || (idx == `SSRC_IDX_IRQSTS) ||
                  (idx == `SSRC_IDX_IRQMSK) || (idx == `SSRC_IDX_STATE);
      end
   endfunction

   // Outputs {codec, power, reset_n} for a state
   function [2:0] outs_of;
      input [4:0] st;
      begin
         case (st)
            ST_START: outs_of = 3'h2;
            ST_RUN:   outs_of = 3'h7;
            ST_SDCDC: outs_of = 3'h3;
            default:  outs_of = 3'h0;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg  [11:0] sync1_reg;
   reg  [11:0] sync2_reg;
   reg  [9:0]  awidx_reg;
   reg         awfull_reg;
   reg  [15:0] wdata_reg;
   reg  [1:0]  wstrb_reg;
   reg         wfull_reg;
   reg         bvalid_reg;
   reg  [1:0]  bresp_reg;
   reg         rvalid_reg;
   reg  [1:0]  rresp_reg;
   reg  [15:0] rdata_reg;
   reg  [15:0] softsd_reg;
   reg  [15:0] softsd_next;
   reg  [15:0] error_action_bit_reg;
   reg  [15:0] error_action_bit_next;
   reg  [15:0] cause_reg;
   reg  [15:0] cause_next;
   reg  [2:0]  irqsts_reg;
   reg  [2:0]  irqsts_next;
   reg  [2:0]  irqmsk_reg;
   reg  [2:0]  irqmsk_next;
   reg         arm_reg;
   reg         arm_next;
   reg  [4:0]  state_reg;
   reg  [4:0]  state_next;
   reg  [15:0] cnt_reg;
   reg  [15:0] cnt_next;
   reg  [2:0]  outs_reg;
   reg  [15:0] rd_word;
   wire [11:0] async_in;
   wire        run_lvl;
   wire        cdel_err;
   wire [9:0]  cond;
   wire        do_write;
   wire        ar_take;
   wire [15:0] wmask;
   wire        wr_hit;
   wire        swrst;
   wire        live;
   wire [15:0] cause_new;
   wire        sd_start;
   wire        step_done;
   wire [2:0]  irq_set;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   assign async_in = {run_pin_i, charge_delay_err_i, temp_level2_i,
                      temp_level1_i, batt_cmp_uv_i, uvlo_i, buck2_uv_i,
                      buck1_uv_i, linreg4_uv_i, linreg3_uv_i,
                      linreg2_uv_i, linreg1_uv_i};

   // Two stages; only the second stage is read by logic
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_reg <= 12'h000;
         sync2_reg <= 12'h000;
      end else begin
         sync1_reg <= async_in;
         sync2_reg <= sync1_reg;
      end
   end

   assign run_lvl  = sync2_reg[11];
   assign cdel_err = sync2_reg[10];
   assign cond     = sync2_reg[9:0];   // Same order as cause bits 9:0

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   // Address and data are held until both are present
   assign s_axi_awready_o = ~awfull_reg & ~bvalid_reg;
   assign s_axi_wready_o  = ~wfull_reg & ~bvalid_reg;
   assign s_axi_arready_o = ~rvalid_reg;
   assign s_axi_bvalid_o  = bvalid_reg;
   assign s_axi_bresp_o   = bresp_reg;
   assign s_axi_rvalid_o  = rvalid_reg;
   assign s_axi_rresp_o   = rresp_reg;
   assign s_axi_rdata_o   = {16'h0000, rdata_reg};

   assign do_write = awfull_reg & wfull_reg & ~bvalid_reg;
   assign ar_take  = s_axi_arvalid_i & ~rvalid_reg;
   assign wr_hit   = do_write & mapped(awidx_reg);

   // Byte-lane mask for the low 16 bits
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : lane
         assign wmask[8*g +: 8] = {8{wstrb_reg[g]}};
      end
   endgenerate

   // Write channel capture and response
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         awidx_reg  <= 10'h000;
         awfull_reg <= 1'b0;
         wdata_reg  <= 16'h0000;
         wstrb_reg  <= 2'h0;
         wfull_reg  <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg  <= `SSRC_RESP_OK;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            awidx_reg  <= s_axi_awaddr_i[11:2];
            awfull_reg <= 1'b1;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            wdata_reg <= s_axi_wdata_i[15:0];
            wstrb_reg <= s_axi_wstrb_i[1:0];
            wfull_reg <= 1'b1;
         end
         if (do_write) begin
            awfull_reg <= 1'b0;
            wfull_reg  <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg  <= mapped(awidx_reg) ? `SSRC_RESP_OK
                                            : `SSRC_RESP_ERR;
         end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Read data selection
   always @* begin
      rd_word = 16'h0000;
      case (s_axi_araddr_i[11:2])
         `SSRC_IDX_ID:     rd_word = DEV_ID;
         `SSRC_IDX_REV:    rd_word[`SSRC_REV_LSB +: 3] = REV_ID;
         `SSRC_IDX_SOFTSD: rd_word = softsd_reg;
         `SSRC_IDX_ERROR_ACTION_BIT: rd_word = error_action_bit_reg;
         `SSRC_IDX_CAUSE:  rd_word = cause_reg;
         `SSRC_IDX_IRQSTS: rd_word[2:0] = irqsts_reg;
         `SSRC_IDX_IRQMSK: rd_word[2:0] = irqmsk_reg;
         `SSRC_IDX_STATE:  rd_word[6:0] = {run_lvl, arm_reg, state_reg};
         default:          rd_word = 16'h0000;
      endcase
   end

   // Read channel; served in every state
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= `SSRC_RESP_OK;
         rdata_reg  <= 16'h0000;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_word;
         rresp_reg  <= mapped(s_axi_araddr_i[11:2]) ? `SSRC_RESP_OK
                                                    : `SSRC_RESP_ERR;
      end else if (s_axi_rready_i) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Shutdown triggers
   // ----------------------------------------------------------------
   // Any write at index zero is a software reset
   assign swrst = wr_hit & (awidx_reg == `SSRC_IDX_ID);

   // Triggers count only while powered or powering up
   assign live = state_reg[1] | state_reg[2];

   assign cause_new = {2'h0,
                       live & softsd_reg[`SSRC_SOFTSD_BIT],
                       1'b0,
                       live & ~run_lvl,
                       live & cdel_err,
                       {10{live}} & cond & error_action_bit_reg[`SSRC_COND_MSB:0]};
   assign sd_start  = |cause_new;
   assign step_done = (cnt_reg == STEP_LAST);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // Ordered power-up and power-down
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            // Raised run pin restarts when armed
            if (arm_reg && run_lvl)
               state_next = ST_START;
         end
         ST_START: begin
            if (sd_start)
               state_next = ST_SDCDC;
            else if (step_done)
               state_next = ST_RUN;
         end
         ST_RUN: begin
            if (sd_start)
               state_next = ST_SDCDC;
         end
         ST_SDCDC: begin
            // Codec off first to keep the outputs quiet
            if (step_done)
               state_next = ST_SDPWR;
         end
         ST_SDPWR: begin
            if (step_done)
               state_next = ST_OFF;
         end
         default: state_next = ST_OFF;
      endcase
      // Software reset drops everything at once
      if (swrst)
         state_next = ST_OFF;
   end

   // Step timer restarts on every state change
   always @* begin
      if (state_next != state_reg)
         cnt_next = 16'h0000;
      else if (step_done)
         cnt_next = cnt_reg;
      else
         cnt_next = cnt_reg + 16'h0001;
   end

   // Restart arming
   always @* begin
      arm_next = arm_reg;
      // Soft shutdown or reset disarm the pin
      if (swrst || (sd_start && cause_new[`SSRC_CAUSE_SOFT]))
         arm_next = 1'b0;
      // A low pin always re-arms; it wins over the clear
      if (!run_lvl)
         arm_next = 1'b1;
   end

   // ----------------------------------------------------------------
   // Register updates
   // ----------------------------------------------------------------
   assign irq_set = {state_reg[1] & (state_next == ST_RUN),
                     state_reg[4] & (state_next == ST_OFF),
                     sd_start};

   always @* begin
      softsd_next = softsd_reg;
      error_action_bit_next = error_action_bit_reg;
      cause_next  = cause_reg;
      irqsts_next = irqsts_reg;
      irqmsk_next = irqmsk_reg;
      if (wr_hit) begin
         if (awidx_reg == `SSRC_IDX_SOFTSD)
            softsd_next[`SSRC_SOFTSD_BIT] =
               (softsd_reg[`SSRC_SOFTSD_BIT] & ~wmask[`SSRC_SOFTSD_BIT]) |
               (wdata_reg[`SSRC_SOFTSD_BIT] & wmask[`SSRC_SOFTSD_BIT]);
         if (awidx_reg == `SSRC_IDX_ERROR_ACTION_BIT)
            error_action_bit_next[9:0] = (error_action_bit_reg[9:0] & ~wmask[9:0]) |
                               (wdata_reg[9:0] & wmask[9:0]);
         // Write one to clear
         if (awidx_reg == `SSRC_IDX_IRQSTS)
            irqsts_next = irqsts_reg & ~(wdata_reg[2:0] & wmask[2:0]);
         if (awidx_reg == `SSRC_IDX_IRQMSK)
            irqmsk_next = (irqmsk_reg & ~wmask[2:0]) |
                          (wdata_reg[2:0] & wmask[2:0]);
      end
      // Request is consumed so a restart does not re-trip
      if (sd_start && cause_new[`SSRC_CAUSE_SOFT])
         softsd_next[`SSRC_SOFTSD_BIT] = 1'b0;
      // Causes kept until restart or reset
      if (state_reg[0] && state_next == ST_START)
         cause_next = `SSRC_CAUSE_RST;
      if (swrst) begin
         softsd_next = `SSRC_SOFTSD_RST;
         error_action_bit_next = `SSRC_ERROR_ACTION_BIT_RST;
         cause_next  = `SSRC_CAUSE_RST;
         irqsts_next = `SSRC_IRQ_RST;
         irqmsk_next = `SSRC_IRQ_RST;
      end
      cause_next  = cause_next | cause_new;
      irqsts_next = irqsts_next | irq_set;
   end

   // State and register flops
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg  <= ST_OFF;
         cnt_reg    <= 16'h0000;
         arm_reg    <= 1'b1;
         outs_reg   <= 3'h0;
         softsd_reg <= `SSRC_SOFTSD_RST;
         error_action_bit_reg <= `SSRC_ERROR_ACTION_BIT_RST;
         cause_reg  <= `SSRC_CAUSE_RST;
         irqsts_reg <= `SSRC_IRQ_RST;
         irqmsk_reg <= `SSRC_IRQ_RST;
      end else begin
         state_reg  <= state_next;
         cnt_reg    <= cnt_next;
         arm_reg    <= arm_next;
         outs_reg   <= outs_of(state_next);
         softsd_reg <= softsd_next;
         error_action_bit_reg <= error_action_bit_next;
         cause_reg  <= cause_next;
         irqsts_reg <= irqsts_next;
         irqmsk_reg <= irqmsk_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Registered controls follow the state
   assign codec_en_o       = outs_reg[2];
   assign power_en_o       = outs_reg[1];
   assign system_reset_n_o = outs_reg[0];

   // Level interrupt while any unmasked status bit is set
   assign irq_o = |(irqsts_reg & irqmsk_reg);

endmodule

// ### verif/ssrc_chk.sv
// Purpose: Port-level checks of the shutdown and reset controller.
// Assumes: One clock domain; reset asynchronous and active low.
// Notes:   Bound into ssrc_top at the foot of this file.
`timescale 1ns/1ns
module ssrc_chk #(
   parameter [15:0] DEV_ID = 16'h0001
) (
   input wire        clk_i,
   input wire        resetn_i,
   input wire [11:0] s_axi_araddr_i,
   input wire        s_axi_arvalid_i,
   input wire        s_axi_arready_o,
   input wire [31:0] s_axi_rdata_o,
   input wire        s_axi_rvalid_o,
   input wire        run_pin_i,
   input wire        charge_delay_err_i,
   input wire        codec_en_o,
   input wire        power_en_o,
   input wire        system_reset_n_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   property p_rst_unpowered;
      !power_en_o |-> !system_reset_n_o;
   endproperty
   a_rst_unpowered: assert property (p_rst_unpowered)
      else $error("system reset released without power");
   property p_sd_order;
      $fell(codec_en_o) && power_en_o |-> power_en_o [*8];
   endproperty
   a_sd_order: assert property (p_sd_order)
      else $error("power dropped too soon after codec");
   property p_up_order;
      $rose(power_en_o) |-> (!codec_en_o && !system_reset_n_o) [*8];
   endproperty
   a_up_order: assert property (p_up_order)
      else $error("codec or reset released too soon");
   property p_up_pin;
      $rose(power_en_o) |-> $past(run_pin_i, 2) && $past(run_pin_i, 3);
   endproperty
   a_up_pin: assert property (p_up_pin)
      else $error("power-up without run pin high");
   property p_pin_sd;
      codec_en_o && !run_pin_i |-> ##[1:4] !codec_en_o;
   endproperty
   a_pin_sd: assert property (p_pin_sd)
      else $error("run pin low ignored");
   property p_cdel_sd;
      codec_en_o && charge_delay_err_i |-> ##[1:4] !codec_en_o;
   endproperty
   a_cdel_sd: assert property (p_cdel_sd)
      else $error("charge delay error ignored");
   property p_rd_ans;
      s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
   endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("read not answered");
   property p_id_rd;
      s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[11:2] == 10'h000
         |=> s_axi_rdata_o == {16'h0000, DEV_ID};
   endproperty
   a_id_rd: assert property (p_id_rd)
      else $error("wrong identity word");
endmodule

bind ssrc_top ssrc_chk #(.DEV_ID(DEV_ID)) u_chk (
   .clk_i, .resetn_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
   .s_axi_rdata_o, .s_axi_rvalid_o, .run_pin_i, .charge_delay_err_i,
   .codec_en_o, .power_en_o, .system_reset_n_o
);

// ### verif/ssrc_host.sv
// Purpose: Host processor model: AXI4-Lite master and run pin.
// Assumes: Slave readies change only on rising edges.
// Notes:   Answers sampled at the falling edge so no race with the edge.
`timescale 1ns/1ns
module ssrc_host (
   // Clock
   input  wire         clk_i,
   // Write channels
   output logic [11:0] awaddr_o = 12'h000,
   output logic        awvalid_o = 1'b0,
   input  wire         awready_i,
   output logic [31:0] wdata_o = 32'h0000_0000,
   output logic [3:0]  wstrb_o = 4'h3,
   output logic        wvalid_o = 1'b0,
   input  wire         wready_i,
   input  wire  [1:0]  bresp_i,
   input  wire         bvalid_i,
   output logic        bready_o = 1'b0,
   // Read channels
   output logic [11:0] araddr_o = 12'h000,
   output logic        arvalid_o = 1'b0,
   input  wire         arready_i,
   input  wire  [31:0] rdata_i,
   input  wire  [1:0]  rresp_i,
   input  wire         rvalid_i,
   output logic        rready_o = 1'b0,
   // Run pin, high means run
   output logic        run_pin_o = 1'b1
);
   // Write one register; each channel released once taken
   task automatic wr(input [9:0] idx, input [15:0] dat, output [1:0] resp,
                     input [3:0] strb = 4'h3);
      logic a;
      logic w;
      logic b;
      a = 1'b0;
      w = 1'b0;
      @(posedge clk_i);
      awaddr_o  <= {idx, 2'b00};
      wdata_o   <= {16'h0000, dat};
      wstrb_o   <= strb;
      awvalid_o <= 1'b1;
      wvalid_o  <= 1'b1;
      bready_o  <= 1'b1;
      do begin
         @(negedge clk_i);
         a = a | awready_i;
         w = w | wready_i;
         b = bvalid_i;
         resp = bresp_i;
         @(posedge clk_i);
         if (a) awvalid_o <= 1'b0;
         if (w) wvalid_o <= 1'b0;
      end while (!b);
      bready_o <= 1'b0;
   endtask

   // Read one register; data taken with rvalid
   task automatic rd(input [9:0] idx, output [31:0] dat, output [1:0] resp);
      logic a;
      logic v;
      a = 1'b0;
      @(posedge clk_i);
      araddr_o  <= {idx, 2'b00};
      arvalid_o <= 1'b1;
      rready_o  <= 1'b1;
      do begin
         @(negedge clk_i);
         a = a | arready_i;
         v = rvalid_i;
         dat = rdata_i;
         resp = rresp_i;
         @(posedge clk_i);
         if (a) arvalid_o <= 1'b0;
      end while (!v);
      rready_o <= 1'b0;
   endtask

   task automatic pin(input v);
      @(posedge clk_i);
      run_pin_o <= v;
   endtask
endmodule

// ### verif/tb_shutdown_reset_control.sv
// Purpose: Self-checking bench of the shutdown and reset controller.
// Assumes: Host model makes all bus traffic and drives the run pin.
// Notes:   Expectations come from the bench model, never the design.
`timescale 1ns/1ns
`include "ssrc_regs.vh"
module tb_shutdown_reset_control;
   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, run_pin;
   logic        codec_en, power_en, sys_rst_n, irq;
   logic        cdel = 1'b0;
   logic [9:0]  cond = 10'h000;
   logic [31:0] seed = 32'h0000_0012;
   int          miscompares = 0;
   int          n_tests = 0;
   int          m_error_action_bit = `SSRC_ERROR_ACTION_BIT_RST;

   always #10 clk_i = ~clk_i;

   ssrc_top dut (
      .clk_i(clk_i), .resetn_i(resetn_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .run_pin_i(run_pin),
      .charge_delay_err_i(cdel), .temp_level2_i(cond[9]),
      .temp_level1_i(cond[8]), .batt_cmp_uv_i(cond[7]),
      .uvlo_i(cond[6]), .buck2_uv_i(cond[5]), .buck1_uv_i(cond[4]),
      .linreg4_uv_i(cond[3]), .linreg3_uv_i(cond[2]),
      .linreg2_uv_i(cond[1]), .linreg1_uv_i(cond[0]),
      .codec_en_o(codec_en), .power_en_o(power_en),
      .system_reset_n_o(sys_rst_n), .irq_o(irq)
   );

   ssrc_host host (
      .clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
      .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb),
      .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
      .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
      .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
      .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready),
      .run_pin_o(run_pin)
   );

   // Random source, fixed start
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Read a register and compare with the model
   task automatic rd_chk(input [9:0] idx, input logic [31:0] exp);
      host.rd(idx, d, r);
      chk(d, exp);
      chk(r, `SSRC_RESP_OK);
   endtask

   // Bounded wait for the codec and power enable pair
   task automatic wait_st(input logic [1:0] want);
      int n;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while ({codec_en, power_en} !== want && n < 400);
      chk({codec_en, power_en}, want);
      @(posedge clk_i);
   endtask

   // Verdict, single exit of the run
   task end_of_test;
      if (miscompares == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd_chk(`SSRC_IDX_ID, {16'h0000, `SSRC_DEV_ID});
      rd_chk(`SSRC_IDX_REV, {17'h0, `SSRC_REV_ID, 12'h000});
      rd_chk(`SSRC_IDX_SOFTSD, 32'h0);
      rd_chk(`SSRC_IDX_CAUSE, 32'h0);
      host.rd(10'h3ff, d, r);
      chk(r, `SSRC_RESP_ERR);
      wait_st(2'b11);
      chk(sys_rst_n, 1'b1);
      // request bit lane disabled by strobe: no effect
      host.wr(`SSRC_IDX_SOFTSD, 16'h2000, r, 4'h1);
      rd_chk(`SSRC_IDX_SOFTSD, 32'h0);
      chk(codec_en, 1'b1);
      // soft shutdown, start interrupt unmasked, pin ignored
      host.wr(`SSRC_IDX_IRQMSK, 16'h0001, r);
      host.wr(`SSRC_IDX_SOFTSD, 16'h2000, r);
      wait_st(2'b00);
      chk(sys_rst_n, 1'b0);
      chk(irq, 1'b1);
      // Power-up done from the first start, shutdown start now
      rd_chk(`SSRC_IDX_IRQSTS, 32'h5);
      rd_chk(`SSRC_IDX_CAUSE, 32'h2000);
      host.wr(`SSRC_IDX_IRQSTS, 16'h0001, r);
      chk(irq, 1'b0);
      repeat (200) @(posedge clk_i);
      chk(power_en, 1'b0);
      // Pin high, disarmed, sequencer off
      rd_chk(`SSRC_IDX_STATE, 32'h41);
      host.pin(1'b0);
      repeat (4) @(posedge clk_i);
      host.pin(1'b1);
      wait_st(2'b11);
      rd_chk(`SSRC_IDX_CAUSE, 32'h0);
      host.pin(1'b0);
      wait_st(2'b00);
      rd_chk(`SSRC_IDX_CAUSE, 32'h0800);
      host.pin(1'b1);
      wait_st(2'b11);
      cdel <= 1'b1;
      wait_st(2'b01);
      rd_chk(`SSRC_IDX_CAUSE, 32'h0400);
      cdel <= 1'b0;
      wait_st(2'b11);
      // each enabled condition and its cause bit
      for (int i = 0; i < 10; i++) begin
         host.wr(`SSRC_IDX_ERROR_ACTION_BIT, 16'h0001 << i, r);
         cond <= 10'h001 << i;
         wait_st(2'b01);
         rd_chk(`SSRC_IDX_CAUSE, 32'h1 << i);
         cond <= 10'h000;
         wait_st(2'b11);
      end
      // disabled condition leaves the device running
      m_error_action_bit = xs() & 32'h0000_03fe;
      host.wr(`SSRC_IDX_ERROR_ACTION_BIT, m_error_action_bit[15:0], r);
      rd_chk(`SSRC_IDX_ERROR_ACTION_BIT, m_error_action_bit);
      // Every disabled condition at once; bit 0 is always among them
      cond <= ~m_error_action_bit[9:0];
      repeat (20) @(posedge clk_i);
      chk(codec_en, 1'b1);
      cond <= 10'h000;
      // software reset, restart by pin toggle
      d = xs();
      host.wr(`SSRC_IDX_ID, d[15:0], r);
      chk(r, `SSRC_RESP_OK);
      wait_st(2'b00);
      chk(sys_rst_n, 1'b0);
      m_error_action_bit = `SSRC_ERROR_ACTION_BIT_RST;
      rd_chk(`SSRC_IDX_ERROR_ACTION_BIT, m_error_action_bit);
      repeat (100) @(posedge clk_i);
      chk(power_en, 1'b0);
      host.pin(1'b0);
      repeat (4) @(posedge clk_i);
      host.pin(1'b1);
      wait_st(2'b11);
      end_of_test;
   end

   // Hang guard, well beyond the few thousand cycles needed
   initial begin
      repeat (30000) @(posedge clk_i);
      miscompares++;
      end_of_test;
   end
endmodule
